/* verilog/asu_map.vh */
`ifndef ASU_MAP_VH
`define ASU_MAP_VH

// Register map (index addresses on the plain register port)
`define ASU_ADDR_W          4
`define ASU_REG_CTRL        4'h0
`define ASU_REG_PORT_DATA   4'h1
`define ASU_REG_PORT_DIR    4'h2
`define ASU_REG_STATUS      4'h3
`define ASU_REG_RX_DATA     4'h4
`define ASU_REG_TX_DATA     4'h5
`define ASU_REG_BAUD        4'h6

// Control register fields
`define ASU_CTRL_TX_ON      0
`define ASU_CTRL_RX_ON      1
`define ASU_CTRL_OPEN_DRAIN 2
`define ASU_CTRL_CHAR_LEN   3

// Status register fields
`define ASU_ST_RX_FULL      0
`define ASU_ST_NOISE        1
`define ASU_ST_TX_EMPTY     2
`define ASU_ST_TX_DONE      3
`define ASU_ST_TX_HOLDS     4

// Pin group
`define ASU_PIN_COUNT       6
`define ASU_TXD_BIT         1
`define ASU_RXD_BIT         0

// Sample-state numbering
`define ASU_RT_FIRST        5'h01
`define ASU_RT_LAST         5'h10
`define ASU_RT_V3           5'h03
`define ASU_RT_V5           5'h05
`define ASU_RT_V7           5'h07
`define ASU_RT_D8           5'h08
`define ASU_RT_D9           5'h09
`define ASU_RT_D10          5'h0A

// Frame lengths in bit times
`define ASU_BITS_SHORT      4'hA
`define ASU_BITS_LONG       4'hB

// Reset values
`define ASU_BAUD_RESET      16'h0001
`define ASU_BYTE_ZERO       8'h00

`endif

/* verilog/asu_tick_gen.v */
`timescale 1ns/1ps
`include "asu_map.vh"

// Free-running divider giving one pulse per sample tick
module asu_tick_gen (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [15:0] divisor,
    output reg         tick
);
    reg [15:0] count_reg;

    always @(posedge clock) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
            tick      <= 1'b0;
        end else if (count_reg >= divisor - 16'h0001 || divisor == 16'h0000) begin
            count_reg <= 16'h0000;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 16'h0001;
            tick      <= 1'b0;
        end
    end
endmodule // asu_tick_gen

/* verilog/asu_tx_shift.v */
`timescale 1ns/1ps
`include "asu_map.vh"

// Transmit shifter, one bit per 16 ticks, one-deep holding buffer
module asu_tx_shift (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       tick,
    input  wire       tx_on_ctl,
    input  wire       char_len_sel,
    input  wire       load,
    input  wire [7:0] load_data,
    output reg        serial_out,
    output reg        busy,
    output reg        buf_full,
    output reg        done_pulse
);
    reg [9:0] shift_reg;
    reg [3:0] bits_reg;
    reg [3:0] sub_reg;
    reg [7:0] hold_reg;

    always @(posedge clock) begin
        if (!rst_n) begin
            shift_reg  <= 10'h3FF;
            bits_reg   <= 4'h0;
            sub_reg    <= 4'h0;
            hold_reg   <= `ASU_BYTE_ZERO;
            serial_out <= 1'b1;
            busy       <= 1'b0;
            buf_full   <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (load && tx_on_ctl) begin
                hold_reg <= load_data;
                buf_full <= 1'b1;
            end
            if (!tx_on_ctl && !(load && tx_on_ctl))
                buf_full <= 1'b0; // RULE_21
            if (!busy) begin
                serial_out <= 1'b1;
                if (buf_full && tx_on_ctl && tick) begin
                    // LSB first, start bit low, stop bit(s) high
                    shift_reg  <= {1'b1, hold_reg, 1'b0}; // RULE_24
                    bits_reg   <= char_len_sel ? `ASU_BITS_LONG : `ASU_BITS_SHORT; // RULE_22
                    sub_reg    <= 4'h0;
                    busy       <= 1'b1;
                    buf_full   <= load;
                end
            end else if (tick) begin
                serial_out <= shift_reg[0];
                sub_reg    <= sub_reg + 4'h1;
                if (sub_reg == 4'hF) begin
                    shift_reg <= {1'b1, shift_reg[9:1]};
                    bits_reg  <= bits_reg - 4'h1;
                    if (bits_reg == 4'h1) begin
                        busy       <= 1'b0; // RULE_21
                        done_pulse <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // asu_tx_shift

/* verilog/asu_serial_pin.v */
`timescale 1ns/1ps
`include "asu_map.vh"

// Summary of operation
// RULE_01 - Transmitter enabled forces transmit pin buffer on
// RULE_02 - Pin returns to port after character ends
// RULE_03 - Buffer on when direction bit or tx_holds_pin
// RULE_04 - One open-drain select drives all six pins
// RULE_05 - Open-drain disables transmit pin high driver
// RULE_06 - Mux sends serial data or port latch
// RULE_07 - Latch captures every data bit 1 write
// RULE_08 - Data read: latch if output, else pin
// RULE_09 - Software sets release state via direction, data
// RULE_10 - Software uses open-drain for shared lines
// RULE_11 - Receiver samples at sixteen ticks per bit
// RULE_12 - Start search on enable and after stop
// RULE_13 - Start qualifier: three ones then zero
// RULE_14 - State held at one until qualified
// RULE_15 - Verify at 3,5,7; ones restart search
// RULE_16 - Accept start if three of four zero
// RULE_17 - Bit value is vote of 8,9,10
// RULE_18 - Start bit always taken as zero
// RULE_19 - Any disagreeing sample sets working noise
// RULE_20 - End: load data, set full and noise
// RULE_21 - Disabled mid-character: finish, drop queue, flag
// RULE_22 - Character lasts ten or eleven bit times
// RULE_23 - Working noise cleared when search begins; code clears it on enable and when a start qualifies, not after stop
// RULE_24 - Data least significant bit first, framed
module asu_serial_pin (
    input  wire                      clock,
    input  wire                      rst_n,
    input  wire [`ASU_ADDR_W-1:0]    reg_addr,
    input  wire [7:0]                reg_wdata,
    input  wire                      reg_write,
    input  wire                      reg_read,
    output reg  [7:0]                reg_rdata,
    input  wire [`ASU_PIN_COUNT-1:0] pin_in,
    output wire [`ASU_PIN_COUNT-1:0] pin_out,
    output wire [`ASU_PIN_COUNT-1:0] pin_oe_n
);
    localparam S_SEARCH = 2'b00;
    localparam S_VERIFY = 2'b01;
    localparam S_FRAME  = 2'b10;

    reg  [7:0]                ctrl_reg;
    reg  [`ASU_PIN_COUNT-1:0] pin_data_latch;
    reg  [`ASU_PIN_COUNT-1:0] pin_group_d_dir;
    reg  [15:0]               baud_reg;
    reg  [7:0]                rx_data_reg;
    reg                       rx_full_flag;
    reg                       noise_flag;
    reg                       tx_done_flag;
    reg  [`ASU_PIN_COUNT-1:0] pin_meta_reg;
    reg  [`ASU_PIN_COUNT-1:0] pin_sync_reg;

    wire                      tx_on_ctl    = ctrl_reg[`ASU_CTRL_TX_ON];
    wire                      rx_on_ctl    = ctrl_reg[`ASU_CTRL_RX_ON];
    wire                      open_drain_sel = ctrl_reg[`ASU_CTRL_OPEN_DRAIN];
    wire                      char_len_sel = ctrl_reg[`ASU_CTRL_CHAR_LEN];
    wire                      rxd          = pin_sync_reg[`ASU_RXD_BIT];
    wire                      tick;
    wire                      tx_serial;
    wire                      tx_busy;
    wire                      tx_buf_full;
    wire                      tx_done_pulse;
    wire                      tx_holds_pin = tx_on_ctl | tx_busy; // RULE_03
    wire                      tx_load = reg_write && reg_addr == `ASU_REG_TX_DATA;
    wire                      tx_buf_empty_flag = ~tx_buf_full;

    asu_tick_gen u_tick (
        .clock   (clock),
        .rst_n   (rst_n),
        .divisor (baud_reg),
        .tick    (tick)
    );

    asu_tx_shift u_tx (
        .clock        (clock),
        .rst_n        (rst_n),
        .tick         (tick),
        .tx_on_ctl    (tx_on_ctl),
        .char_len_sel (char_len_sel),
        .load         (tx_load),
        .load_data    (reg_wdata),
        .serial_out   (tx_serial),
        .busy         (tx_busy),
        .buf_full     (tx_buf_full),
        .done_pulse   (tx_done_pulse)
    );

    // Pin drivers; open drain only ever pulls low
    genvar gi;
    generate
        for (gi = 0; gi < `ASU_PIN_COUNT; gi = gi + 1) begin : g_pin
            wire owned   = (gi == `ASU_TXD_BIT) && tx_holds_pin;
            wire drive_v = owned ? tx_serial : pin_data_latch[gi]; // RULE_06 RULE_02
            wire buf_on  = pin_group_d_dir[gi] | owned; // RULE_01 RULE_03
            assign pin_out[gi]  = drive_v;
            assign pin_oe_n[gi] = ~(buf_on & ~(open_drain_sel & drive_v)); // RULE_04 RULE_05
        end
    endgenerate

    always @(posedge clock) begin
        if (!rst_n) begin
            pin_meta_reg <= {`ASU_PIN_COUNT{1'b1}};
            pin_sync_reg <= {`ASU_PIN_COUNT{1'b1}};
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Receiver
    reg  [1:0]  state_reg;
    reg  [4:0]  rt_reg;
    reg  [2:0]  hist_reg;
    reg  [1:0]  zero_cnt_reg;
    reg  [2:0]  vote_reg;
    reg         noise_work_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [9:0]  shift_reg;
    reg         rx_on_d_reg;
    reg         rx_done;
    reg         rx_noise;

    wire        vote = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & rxd) | (vote_reg[1] & rxd);
    wire [3:0]  frame_bits = char_len_sel ? `ASU_BITS_LONG : `ASU_BITS_SHORT; // RULE_22
    wire        rx_start = rx_on_ctl & ~rx_on_d_reg;

    always @(posedge clock) begin
        if (!rst_n) begin
            state_reg      <= S_SEARCH;
            rt_reg         <= `ASU_RT_FIRST;
            hist_reg       <= 3'b000;
            zero_cnt_reg   <= 2'b00;
            vote_reg       <= 3'b000;
            noise_work_reg <= 1'b0;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 10'h000;
            rx_on_d_reg    <= 1'b0;
            rx_done        <= 1'b0;
            rx_noise       <= 1'b0;
        end else begin
            rx_on_d_reg <= rx_on_ctl;
            rx_done     <= 1'b0;
            if (!rx_on_ctl || rx_start) begin
                state_reg      <= S_SEARCH; // RULE_12
                rt_reg         <= `ASU_RT_FIRST;
                hist_reg       <= 3'b000;
                noise_work_reg <= 1'b0;
            end else if (tick) begin // RULE_11
                case (state_reg)
                    S_SEARCH: begin
                        hist_reg <= {hist_reg[1:0], rxd};
                        rt_reg   <= `ASU_RT_FIRST; // RULE_14
                        if (hist_reg == 3'b111 && !rxd) begin // RULE_13
                            state_reg      <= S_VERIFY;
                            rt_reg         <= `ASU_RT_FIRST + 5'h01; // RULE_14
                            zero_cnt_reg   <= 2'b00;
                            noise_work_reg <= 1'b0; // RULE_23
                        end
                    end
                    S_VERIFY: begin
                        rt_reg <= rt_reg + 5'h01;
                        if (rt_reg == `ASU_RT_V3 || rt_reg == `ASU_RT_V5 || rt_reg == `ASU_RT_V7) begin
                            if (rxd)
                                noise_work_reg <= 1'b1; // RULE_19
                            if (!rxd)
                                zero_cnt_reg <= zero_cnt_reg + 2'b01;
                        end
                        if (rt_reg == `ASU_RT_V7) begin
                            // Zero at state 1 plus two of three verifies
                            if (zero_cnt_reg + {1'b0, ~rxd} >= 2'b10) begin // RULE_16
                                state_reg   <= S_FRAME;
                                bit_cnt_reg <= 4'h0;
                            end else begin
                                state_reg <= S_SEARCH; // RULE_15
                                hist_reg  <= 3'b000;
                                rt_reg    <= `ASU_RT_FIRST;
                            end
                        end
                    end
                    S_FRAME: begin
                        rt_reg <= (rt_reg == `ASU_RT_LAST) ? `ASU_RT_FIRST : rt_reg + 5'h01;
                        if (rt_reg == `ASU_RT_D8)
                            vote_reg[0] <= rxd;
                        if (rt_reg == `ASU_RT_D9)
                            vote_reg[1] <= rxd;
                        if (rt_reg == `ASU_RT_D10) begin
                            if (vote_reg[0] != rxd || vote_reg[1] != rxd)
                                noise_work_reg <= 1'b1; // RULE_19
                            // Start bit forced low whatever the vote says
                            shift_reg   <= {(bit_cnt_reg == 4'h0) ? 1'b0 : vote, shift_reg[9:1]}; // RULE_17 RULE_18
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == frame_bits - 4'h1) begin
                                rx_done   <= 1'b1;
                                rx_noise  <= noise_work_reg | (vote_reg[0] != rxd) | (vote_reg[1] != rxd);
                                state_reg <= S_SEARCH; // RULE_12
                                hist_reg  <= 3'b000;
                                rt_reg    <= `ASU_RT_FIRST;
                            end
                        end
                    end
                    default: state_reg <= S_SEARCH;
                endcase
            end
        end
    end

    // Data bits sit below the stop bit(s), LSB received first
    wire [7:0] rx_byte = char_len_sel ? shift_reg[7:0] : shift_reg[8:1]; // RULE_24
    wire       rd_rxdata = reg_read && reg_addr == `ASU_REG_RX_DATA;

    always @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg        <= `ASU_BYTE_ZERO;
            pin_data_latch  <= {`ASU_PIN_COUNT{1'b0}};
            pin_group_d_dir <= {`ASU_PIN_COUNT{1'b0}};
            baud_reg        <= `ASU_BAUD_RESET;
            rx_data_reg     <= `ASU_BYTE_ZERO;
            rx_full_flag    <= 1'b0;
            noise_flag      <= 1'b0;
            tx_done_flag    <= 1'b0;
        end else begin
            if (reg_write) begin
                case (reg_addr)
                    `ASU_REG_CTRL:      ctrl_reg <= reg_wdata;
                    `ASU_REG_PORT_DATA: pin_data_latch <= reg_wdata[`ASU_PIN_COUNT-1:0]; // RULE_07
                    `ASU_REG_PORT_DIR:  pin_group_d_dir <= reg_wdata[`ASU_PIN_COUNT-1:0];
                    `ASU_REG_BAUD:      baud_reg <= {8'h00, reg_wdata};
                    default: ;
                endcase
            end
            // Data read clears flags; a new set wins
            if (rd_rxdata) begin
                rx_full_flag <= 1'b0;
                noise_flag   <= 1'b0;
            end
            if (tx_load)
                tx_done_flag <= 1'b0;
            if (rx_done) begin
                rx_data_reg  <= rx_byte; // RULE_20
                rx_full_flag <= 1'b1;
                noise_flag   <= rx_noise; // RULE_20
            end
            if (tx_done_pulse && !tx_buf_full)
                tx_done_flag <= 1'b1; // RULE_21
        end
    end

    // Port read: latch when output, live pin when input
    wire [`ASU_PIN_COUNT-1:0] port_view =
        (pin_group_d_dir & pin_data_latch) | (~pin_group_d_dir & pin_sync_reg); // RULE_08

    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= `ASU_BYTE_ZERO;
        end else if (reg_read) begin
            case (reg_addr)
                `ASU_REG_CTRL:      reg_rdata <= ctrl_reg;
                `ASU_REG_PORT_DATA: reg_rdata <= {2'b00, port_view};
                `ASU_REG_PORT_DIR:  reg_rdata <= {2'b00, pin_group_d_dir};
                `ASU_REG_STATUS:    reg_rdata <= {3'b000, tx_holds_pin, tx_done_flag,
                                                  tx_buf_empty_flag, noise_flag, rx_full_flag};
                `ASU_REG_RX_DATA:   reg_rdata <= rx_data_reg;
                `ASU_REG_BAUD:      reg_rdata <= baud_reg[7:0];
                default:            reg_rdata <= `ASU_BYTE_ZERO;
            endcase
        end else begin
            reg_rdata <= `ASU_BYTE_ZERO;
        end
    end

endmodule // asu_serial_pin

/* bench/asu_serial_pin_props.sv */
`timescale 1ns/1ps
`include "asu_map.vh"
module asu_pin_props (
    input wire                      clock,
    input wire                      rst_n,
    input wire [`ASU_ADDR_W-1:0]    reg_addr,
    input wire [7:0]                reg_wdata,
    input wire                      reg_write,
    input wire                      reg_read,
    input wire [7:0]                reg_rdata,
    input wire [`ASU_PIN_COUNT-1:0] pin_in,
    input wire [`ASU_PIN_COUNT-1:0] pin_out,
    input wire [`ASU_PIN_COUNT-1:0] pin_oe_n
);
    // Longest frame plus sync margin, valid for divisors up to 2
    localparam logic [8:0] REL_CYC = 9'h190;
    logic [5:0] dat_reg, dir_reg;
    logic       tx_reg, od_reg, ever_reg, txw_reg, rdl_reg, rdp_reg, pin_q_reg;
    logic [8:0] rel_reg;
    logic [2:0] stab_reg;
    wire        ctl_wr  = reg_write && reg_addr == `ASU_REG_CTRL;
    wire        port_rd = reg_read && reg_addr == `ASU_REG_PORT_DATA;
    wire        gp_ok   = pin_out[1] == dat_reg[1] && pin_oe_n[1] == (~dir_reg[1] | (od_reg & pin_out[1]));
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {dat_reg, dir_reg, tx_reg, od_reg, ever_reg, txw_reg, rdl_reg, rdp_reg, pin_q_reg} <= '0;
            rel_reg  <= 9'h000;
            stab_reg <= 3'h0;
        end else begin
            if (ctl_wr) {od_reg, tx_reg} <= {reg_wdata[`ASU_CTRL_OPEN_DRAIN], reg_wdata[`ASU_CTRL_TX_ON]};
            if (reg_write && reg_addr == `ASU_REG_PORT_DATA) dat_reg <= reg_wdata[5:0];
            if (reg_write && reg_addr == `ASU_REG_PORT_DIR) dir_reg <= reg_wdata[5:0];
            if (reg_write && reg_addr == `ASU_REG_TX_DATA) txw_reg <= 1'h1;
            ever_reg  <= ever_reg | (ctl_wr & reg_wdata[`ASU_CTRL_TX_ON]);
            rel_reg   <= tx_reg ? 9'h000 : (rel_reg == REL_CYC ? rel_reg : rel_reg + 9'h001);
            pin_q_reg <= pin_in[1];
            stab_reg  <= pin_in[1] != pin_q_reg ? 3'h0 : (stab_reg == 3'h7 ? stab_reg : stab_reg + 3'h1);
            rdl_reg   <= port_rd && dir_reg[1];
            rdp_reg   <= port_rd && !dir_reg[1] && stab_reg == 3'h7 && pin_in[1] == pin_q_reg;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_tx_forces_oe: assert property (tx_reg |-> pin_oe_n[1] == (od_reg & pin_out[1]))
        else $error("transmit pin buffer off with transmitter on");
    chk_dir_drives_oe: assert property (dir_reg[1] |-> pin_oe_n[1] == (od_reg & pin_out[1]))
        else $error("transmit pin buffer off with direction set");
    chk_od_no_high: assert property (od_reg |-> (pin_out & ~pin_oe_n) == 6'h00)
        else $error("pin driven high in open drain");
    chk_group_follows: assert property (pin_out[5:2] == dat_reg[5:2] &&
        pin_oe_n[5:2] == (~dir_reg[5:2] | ({4{od_reg}} & pin_out[5:2])))
        else $error("pin group drive wrong");
    chk_gp_before_tx: assert property (!ever_reg |-> gp_ok)
        else $error("transmit pin not from port latch");
    chk_gp_after_tx: assert property (ever_reg && !tx_reg && rel_reg == REL_CYC |-> gp_ok)
        else $error("transmit pin not released to port");
    chk_idle_line_high: assert property (tx_reg && !txw_reg |-> pin_out[1])
        else $error("idle transmit line not high");
    chk_read_latch: assert property (rdl_reg |-> reg_rdata[1] == dat_reg[1])
        else $error("port read not latch");
    chk_read_pin: assert property (rdp_reg |-> reg_rdata[1] == pin_q_reg)
        else $error("port read not pin level");
endmodule // asu_pin_props

bind asu_serial_pin asu_pin_props u_props (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

/* bench/asu_remote_tx.sv */
`timescale 1ns/1ps
module asu_remote_tx #(parameter int TICK_CYC = 2) (
    input  wire  clock,
    output logic line
);
    initial line = 1'h1;
    task automatic hold(input logic lvl, input int ticks);
        @(posedge clock);
        line <= lvl;
        repeat (ticks * TICK_CYC - 1) @(posedge clock);
    endtask
    // Glitch inverts the line for g_len ticks from tick g_at of the frame
    task automatic send(input logic [8:0] data, input logic nine, input int g_at, input int g_len);
        logic [10:0] frame;
        int          nbits;
        frame = nine ? {1'h1, data, 1'h0} : {2'h3, data[7:0], 1'h0};
        nbits = nine ? 11 : 10;
        for (int t = 0; t < nbits * 16; t++) hold(frame[t / 16] ^ (t >= g_at && t < g_at + g_len), 1);
    endtask
endmodule // asu_remote_tx

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "asu_map.vh"
module tb_top;
    logic       clock, rst_n, reg_write, reg_read;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, v;
    wire  [7:0] reg_rdata;
    wire  [5:0] pin_in, pin_out, pin_oe_n;
    wire        rx_line;
    int         n_fail, num_checks;
    // Pull-ups on all pins; the far transmitter owns the receive pin
    assign pin_in[5:1] = pin_out[5:1] | pin_oe_n[5:1];
    assign pin_in[0]   = rx_line & (pin_out[0] | pin_oe_n[0]);
    asu_serial_pin DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    asu_remote_tx #(.TICK_CYC(2)) u_rem (.clock(clock), .line(rx_line));
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic give_up(input string w);
        n_fail++;
        $display("[ERR] %0t %s timeout", $time, w);
        final_report();
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        @(negedge clock);
        d = reg_rdata;
        @(posedge clock);
    endtask
    function automatic logic [7:0] pin1();
        return {6'h00, pin_oe_n[1], pin_out[1]};
    endfunction
    task automatic wait_full();
        int i;
        for (i = 0; i < 400; i++) begin
            rd(`ASU_REG_STATUS, v);
            if (v[0] === 1'h1) break;
        end
        if (i == 400) give_up("receive");
    endtask
    task automatic rx_expect(input logic [7:0] d, input logic n);
        wait_full();
        chk(v & 8'h03, {6'h00, n, 1'h1}, "receive flags");
        rd(`ASU_REG_RX_DATA, v);
        chk(v, d, "receive data");
        rd(`ASU_REG_STATUS, v);
        chk(v & 8'h03, 8'h00, "flags after read");
    endtask
    task automatic t_port();
        rd(`ASU_REG_CTRL, v);
        chk(v, 8'h00, "control reset");
        rd(`ASU_REG_BAUD, v);
        chk(v, 8'h01, "divisor reset");
        wr(4'hF, 8'hFF);
        rd(4'hF, v);
        chk(v, 8'h00, "unmapped read");
        wr(`ASU_REG_PORT_DATA, 8'h00);
        rd(`ASU_REG_PORT_DATA, v);
        chk(v & 8'h02, 8'h02, "floating pin read");
        wr(`ASU_REG_PORT_DIR, 8'h02);
        chk(pin1(), 8'h00, "pin driven low");
        rd(`ASU_REG_PORT_DIR, v);
        chk(v, 8'h02, "direction read");
        rd(`ASU_REG_PORT_DATA, v);
        chk(v & 8'h02, 8'h00, "latch read");
        wr(`ASU_REG_PORT_DATA, 8'h02);
        chk(pin1(), 8'h01, "pin driven high");
        $display("port test done");
    endtask
    task automatic t_od();
        wr(`ASU_REG_CTRL, 8'h04);
        chk({2'h0, pin_oe_n}, 8'h3F, "open drain high floats");
        wr(`ASU_REG_PORT_DIR, 8'h3F);
        wr(`ASU_REG_PORT_DATA, 8'h3C);
        chk({2'h0, pin_oe_n}, 8'h3C, "group open drain");
        wr(`ASU_REG_PORT_DIR, 8'h00);
        wr(`ASU_REG_PORT_DATA, 8'h02);
        wr(`ASU_REG_CTRL, 8'h00);
        $display("open drain test done");
    endtask
    task automatic t_tx();
        int         i;
        logic [8:0] got;
        wr(`ASU_REG_CTRL, 8'h01);
        chk(pin1(), 8'h01, "transmitter owns pin");
        wr(`ASU_REG_TX_DATA, 8'hA5);
        wr(`ASU_REG_TX_DATA, 8'h3C);
        for (i = 0; i < 2000 && pin_in[1] !== 1'h0; i++) @(posedge clock);
        if (i == 2000) give_up("transmit start");
        wr(`ASU_REG_CTRL, 8'h00);
        wr(`ASU_REG_PORT_DATA, 8'h00);
        rd(`ASU_REG_STATUS, v);
        chk(v & 8'h1C, 8'h14, "holds pin mid character");
        repeat (30) @(posedge clock);
        rd(`ASU_REG_PORT_DATA, v);
        chk(v & 8'h02, 8'h02, "live pin read in transmit");
        repeat (10) @(posedge clock);
        for (i = 0; i < 9; i++) begin
            got[i] = pin_in[1];
            repeat (32) @(posedge clock);
        end
        chk(got[7:0], 8'hA5, "serial data");
        chk({7'h00, got[8]}, 8'h01, "stop bit");
        repeat (16) @(posedge clock);
        rd(`ASU_REG_STATUS, v);
        chk(v & 8'h1C, 8'h0C, "transmit done flags");
        chk(pin1(), 8'h02, "pin back to port");
        for (i = 0; i < 400 && pin_in[1] === 1'h1; i++) @(posedge clock);
        chk({7'h00, pin_in[1]}, 8'h01, "queued character dropped");
        $display("transmit pin test done");
    endtask
    task automatic t_rx();
        logic [7:0] dv [4] = '{8'hA3, 8'h55, 8'hC6, 8'h3C};
        int         go [4] = '{56, -1, 8, 152};
        int         gl [4] = '{1, 0, 3, 1};
        wr(`ASU_REG_CTRL, 8'h02);
        u_rem.hold(1'h1, 40);
        u_rem.hold(1'h0, 1);
        u_rem.hold(1'h1, 180);
        rd(`ASU_REG_STATUS, v);
        chk(v & 8'h01, 8'h00, "glitch rejected");
        for (int k = 0; k < 4; k++) fork
            u_rem.send({1'h0, dv[k]}, 1'h0, go[k], gl[k]);
            rx_expect(dv[k], gl[k] != 0);
        join
        wr(`ASU_REG_CTRL, 8'h0A);
        fork
            begin
                u_rem.send(9'h05A, 1'h1, -1, 0);
                u_rem.send(9'h1E1, 1'h1, -1, 0);
            end
            begin
                rx_expect(8'h5A, 1'h0);
                rx_expect(8'hE1, 1'h0);
            end
        join
        $display("receive test done");
    endtask
    initial begin
        {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        n_fail = 0;
        num_checks = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        t_port();
        t_od();
        wr(`ASU_REG_BAUD, 8'h02);
        t_tx();
        t_rx();
        final_report();
    end
endmodule // tb_top
